/* File: src/fpes_cmd_dec.sv */
/*
  Command-cycle decoder: walks the bus write cycles of read/reset,
  identity read and protection-bit erase, and pulses one result each.
  Assumes one write strobe per completed bus write, never back to back.
*/
`timescale 1ns/10ps
`include "fpes_defines.svh"
module fpes_cmd_dec (
  // clock and reset
  input  wire logic    ref_clk,
  input  wire logic    rst,
  // link to the operation logic
  fpes_cmd_if.dec      cmd
);

  fpes_pkg::fpes_dec_t step_q;
  logic [7:0]          ahi;
  logic [7:0]          dat;

  assign ahi = cmd.wr_addr[`FPES_CMD_HI:`FPES_CMD_LO];
  assign dat = cmd.wr_data;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      step_q         <= fpes_pkg::DEC_C1;
      cmd.rd_reset   <= 1'b0;
      cmd.id_enter   <= 1'b0;
      cmd.id_select  <= 1'b0;
      cmd.pberase_go <= 1'b0;
    end
    else
    begin
      cmd.rd_reset   <= 1'b0;
      cmd.id_enter   <= 1'b0;
      cmd.id_select  <= 1'b0;
      cmd.pberase_go <= 1'b0;
      if (cmd.busy)
      begin
        step_q <= fpes_pkg::DEC_C1;
      end
      else if (cmd.wr_valid)
      begin
        step_q <= fpes_pkg::DEC_C1;
        case (step_q)
          fpes_pkg::DEC_C1:
          begin
            if (dat == `FPES_D_RST)
              cmd.rd_reset <= 1'b1;
            else if (ahi == `FPES_A_54 && dat == `FPES_D_AA)
              step_q <= fpes_pkg::DEC_C2;
            else if (cmd.id_mode)
              cmd.id_select <= 1'b1;
          end
          fpes_pkg::DEC_C2:
            if (ahi == `FPES_A_AA && dat == `FPES_D_55)
              step_q <= fpes_pkg::DEC_C3;
          fpes_pkg::DEC_C3:
          begin
            if (ahi == `FPES_A_54 && dat == `FPES_D_RST)
              cmd.rd_reset <= 1'b1;
            else if (ahi == `FPES_A_54 && dat == `FPES_D_ID)
              cmd.id_enter <= 1'b1;
            else if (ahi == `FPES_A_54 && dat == `FPES_D_PBE)
              step_q <= fpes_pkg::DEC_C4;
          end
          fpes_pkg::DEC_C4:
            if (ahi == `FPES_A_54 && dat == `FPES_D_AA)
              step_q <= fpes_pkg::DEC_C5;
          fpes_pkg::DEC_C5:
            if (ahi == `FPES_A_AA && dat == `FPES_D_55)
              step_q <= fpes_pkg::DEC_C6;
          fpes_pkg::DEC_C6:
            if (ahi == `FPES_A_54 && dat == `FPES_D_PBE)
              step_q <= fpes_pkg::DEC_C7;
          fpes_pkg::DEC_C7:
            if (dat == `FPES_D_PBE)
              cmd.pberase_go <= 1'b1;
          default:
            step_q <= fpes_pkg::DEC_C1;
        endcase
      end
    end
  end

endmodule

/* File: src/fpes_cmd_if.sv */
/*
  Carrier between the operation logic and the command decoder.
  Assumes both ends share ref_clk.
*/
`timescale 1ns/10ps
interface fpes_cmd_if;
  logic        wr_valid;
  logic [15:0] wr_addr;
  logic [7:0]  wr_data;
  logic        busy;
  logic        id_mode;
  logic        rd_reset;
  logic        id_enter;
  logic        id_select;
  logic        pberase_go;

  modport ctl (output wr_valid, wr_addr, wr_data, busy, id_mode,
               input rd_reset, id_enter, id_select, pberase_go);
  modport dec (input wr_valid, wr_addr, wr_data, busy, id_mode,
               output rd_reset, id_enter, id_select, pberase_go);
endinterface

/* File: src/fpes_defines.svh */
/*
  Constants for the protection-bit erase, status and identity-read block:
  register addresses, field positions, reset values, command codes, timings.
  Assumes a 20 MHz system clock and an APB bus with 32-bit data.
*/
`ifndef FPES_DEFINES_SVH
`define FPES_DEFINES_SVH

// register byte addresses
`define FPES_SEC_ADDR        32'h4004_0500
`define FPES_STAT_ADDR       32'h4004_0520
`define FPES_FLASH_HI        16'h0000

// field positions and widths
`define FPES_RDY_BIT         0
`define FPES_SEC_BIT         0
`define FPES_PROT_LSB        16
`define FPES_BLOCKS          6
`define FPES_ID_HI           15
`define FPES_ID_LO           14
`define FPES_CMD_HI          15
`define FPES_CMD_LO          8

// reset values
`define FPES_RDY_RST         1'b1
`define FPES_SEC_RST         1'b1
`define FPES_PROT_RST        6'h00

// command address bytes and data codes
`define FPES_A_54            8'h54
`define FPES_A_AA            8'haa
`define FPES_D_AA            8'haa
`define FPES_D_55            8'h55
`define FPES_D_RST           8'hf0
`define FPES_D_ID            8'h90
`define FPES_D_PBE           8'h6a

// timing
`define FPES_CLK_MHZ         20
`define FPES_READ_WAIT_US    2000
`define FPES_ARRAY_ERASE_US  100
`define FPES_PROT_ERASE_US   20
`define FPES_READ_WAIT_CYC   (`FPES_READ_WAIT_US * `FPES_CLK_MHZ)
`define FPES_ARRAY_ERASE_CYC (`FPES_ARRAY_ERASE_US * `FPES_CLK_MHZ)
`define FPES_PROT_ERASE_CYC  (`FPES_PROT_ERASE_US * `FPES_CLK_MHZ)

`endif

/* File: src/fpes_pkg.sv */
/*
  Types for the protection-bit erase block: decoder and operation states.
  Assumes nothing of its surroundings.
*/
package fpes_pkg;

  typedef enum logic [2:0] {
    DEC_C1,
    DEC_C2,
    DEC_C3,
    DEC_C4,
    DEC_C5,
    DEC_C6,
    DEC_C7
  } fpes_dec_t;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_ARRAY,
    OP_PROT,
    OP_FAIL
  } fpes_op_t;

endpackage

/* File: src/fpes_top.sv */
/*
  Protection-bit erase, status and identity-read block of a flash sequencer,
  with its status and security registers and a small flip-flop data array,
  reached over APB.
  Assumes APB master on ref_clk, rst as hardware reset, por as power-on reset.
*/
// The APB slave port was decided locally.
// Function
// - all blocks protected and security enabled: erase whole array, then protection bits.
// - after whole-array path, status register reads only ready set.
// - otherwise erase clears protection flags; they read zero afterwards.
// - new command writes ignored while erase runs; only hardware reset stops.
// - normal completion returns to array read mode.
// - no internal verify; software reads back array.
// - ready flag bit 0 low while running, high when done; resets high.
// - failed operation keeps ready flag low until hardware reset.
// - status bits 21:16 show block 0..5 protection; protected refuses writes.
// - stuck state recovered by reset; array reads wait about 2 ms.
// - identity mode reads return id data chosen by address bits 15:14 of the last fourth-cycle write.
// - identity mode holds, accepting fourth-cycle writes, until read/reset or erase start.
// - security enable bit resets to one, only by power-on reset.
`timescale 1ns/10ps
`include "fpes_defines.svh"
module fpes_top #(
  parameter int unsigned ARRAY_WORDS     = 16,
  parameter int unsigned READ_WAIT_CYC   = `FPES_READ_WAIT_CYC,
  parameter int unsigned ARRAY_ERASE_CYC = `FPES_ARRAY_ERASE_CYC,
  parameter int unsigned PROT_ERASE_CYC  = `FPES_PROT_ERASE_CYC,
  // stored protection pattern loaded at power-on
  parameter logic [`FPES_BLOCKS-1:0] PROT_INIT = `FPES_PROT_RST,
  parameter logic [31:0] ID_CODE0        = 32'h0000_0011, // arbitrary
  parameter logic [31:0] ID_CODE1        = 32'h0000_0022, // arbitrary
  parameter logic [31:0] ID_CODE2        = 32'h0000_0033, // arbitrary
  parameter logic [31:0] ID_CODE3        = 32'h0000_0044  // arbitrary
) (
  // clock and resets
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        por,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // erase fault from the array
  input  wire logic        op_fault,
  // status
  output logic             ready_flag
);

  localparam int IW = (ARRAY_WORDS > 1) ? $clog2(ARRAY_WORDS) : 1;

  // parameter checks (ids are arbitrary values)
  if (ARRAY_WORDS < 2 || ARRAY_WORDS > 16384 || (ARRAY_WORDS & (ARRAY_WORDS - 1)) != 0)
  begin : g_bad_words
    $error("ARRAY_WORDS must be a power of two from 2 to 16384");
  end
  if (READ_WAIT_CYC < 1 || ARRAY_ERASE_CYC < 1 || PROT_ERASE_CYC < 1)
  begin : g_bad_cyc
    $error("cycle counts must be at least one");
  end

  // hardware or power-on reset
  logic rst_any;
  assign rst_any = rst | por;

  fpes_cmd_if cmd ();

  fpes_cmd_dec u_dec (
    .ref_clk (ref_clk),
    .rst     (rst_any),
    .cmd     (cmd)
  );

  logic [1:0]               cmd_sel_q;
  fpes_pkg::fpes_op_t       op_q;
  logic [31:0]              tmr_q;
  logic [31:0]              wait_q;
  logic                     avail_q;
  logic                     id_mode_q;
  logic [1:0]               id_sel_q;
  logic                     sec_q;
  logic [`FPES_BLOCKS-1:0]  prot_q;
  logic [31:0]              mem_q [ARRAY_WORDS];
  logic                     acc;
  logic                     hit_sec;
  logic                     hit_stat;
  logic                     hit_fl;
  logic                     fl_wr;
  logic                     fl_rd_ok;
  logic                     done;
  logic [IW-1:0]            idx;
  logic [31:0]              stat_word;
  logic [31:0]              id_word;

  assign acc       = psel & penable;
  assign hit_sec   = paddr == `FPES_SEC_ADDR;
  assign hit_stat  = paddr == `FPES_STAT_ADDR;
  assign hit_fl    = paddr[31:16] == `FPES_FLASH_HI;
  assign idx       = paddr[IW+1:2];
  assign fl_wr     = acc & pready & pwrite & hit_fl;
  assign fl_rd_ok  = avail_q & (op_q == fpes_pkg::OP_IDLE);
  assign done      = tmr_q == 32'd0;

  // status word: reserved bits zero
  always_comb
  begin
    stat_word = 32'h0000_0000;
    stat_word[`FPES_RDY_BIT] = ready_flag;
    stat_word[`FPES_PROT_LSB +: `FPES_BLOCKS] = prot_q;
  end

  always_comb
  begin
    case (id_sel_q)
      2'h0:    id_word = ID_CODE0;
      2'h1:    id_word = ID_CODE1;
      2'h2:    id_word = ID_CODE2;
      default: id_word = ID_CODE3;
    endcase
  end

  // command write path into the decoder
  assign cmd.wr_valid = fl_wr;
  assign cmd.wr_addr  = paddr[15:0];
  assign cmd.wr_data  = pwdata[7:0];
  assign cmd.busy     = op_q != fpes_pkg::OP_IDLE;
  assign cmd.id_mode  = id_mode_q;

  // apb answer: registered, one wait state; array reads while idle are held until read availability
  always_ff @(posedge ref_clk or posedge rst_any)
  begin
    if (rst_any)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      if (psel & penable & ~pready)
      begin
        if (hit_sec)
        begin
          pready <= 1'b1;
          prdata <= {31'h0000_0000, sec_q};
        end
        else if (hit_stat)
        begin
          pready <= 1'b1;
          prdata <= stat_word;
        end
        else if (hit_fl & pwrite)
        begin
          pready <= 1'b1;
          prdata <= 32'h0000_0000;
        end
        else if (hit_fl & fl_rd_ok)
        begin
          pready <= 1'b1;
          prdata <= id_mode_q ? id_word : mem_q[idx];
        end
        else if (hit_fl & cmd.busy)
        begin
          pready <= 1'b1;
          prdata <= 32'h0000_0000;
        end
        else if (~hit_fl)
        begin
          pready  <= 1'b1;
          pslverr <= 1'b1;
          prdata  <= 32'h0000_0000;
        end
      end
    end
  end

  // security enable: power-on reset only
  always_ff @(posedge ref_clk or posedge por)
  begin
    if (por)
      sec_q <= `FPES_SEC_RST;
    else if (acc & pready & pwrite & hit_sec)
      sec_q <= pwdata[`FPES_SEC_BIT];
  end

  // array read availability after reset
  always_ff @(posedge ref_clk or posedge rst_any)
  begin
    if (rst_any)
    begin
      wait_q  <= 32'd0;
      avail_q <= 1'b0;
    end
    else if (~avail_q)
    begin
      wait_q <= wait_q + 32'd1;
      if (wait_q == READ_WAIT_CYC - 1)
        avail_q <= 1'b1;
    end
  end

  // operation sequencer
  always_ff @(posedge ref_clk or posedge rst_any)
  begin
    if (rst_any)
    begin
      op_q       <= fpes_pkg::OP_IDLE;
      tmr_q      <= 32'd0;
      ready_flag <= `FPES_RDY_RST;
    end
    else
    begin
      if (tmr_q != 32'd0)
        tmr_q <= tmr_q - 32'd1;
      case (op_q)
        fpes_pkg::OP_IDLE:
          if (cmd.pberase_go)
          begin
            ready_flag <= 1'b0;
            if (sec_q && (&prot_q))
            begin
              op_q  <= fpes_pkg::OP_ARRAY;
              tmr_q <= ARRAY_ERASE_CYC - 1;
            end
            else
            begin
              op_q  <= fpes_pkg::OP_PROT;
              tmr_q <= PROT_ERASE_CYC - 1;
            end
          end
        fpes_pkg::OP_ARRAY:
          if (op_fault)
            op_q <= fpes_pkg::OP_FAIL;
          else if (done)
          begin
            op_q  <= fpes_pkg::OP_PROT;
            tmr_q <= PROT_ERASE_CYC - 1;
          end
        fpes_pkg::OP_PROT:
          if (op_fault)
            op_q <= fpes_pkg::OP_FAIL;
          else if (done)
          begin
            op_q       <= fpes_pkg::OP_IDLE;
            ready_flag <= 1'b1;
          end
        fpes_pkg::OP_FAIL:
          ready_flag <= 1'b0;
        default:
          op_q <= fpes_pkg::OP_IDLE;
      endcase
    end
  end

  // protection flags: nonvolatile, cleared at end of the erase
  always_ff @(posedge ref_clk or posedge por)
  begin
    if (por)
      prot_q <= PROT_INIT;
    else if (op_q == fpes_pkg::OP_PROT && done && ~op_fault)
      prot_q <= '0;
  end

  // data array: erased whole before the protection bits, no verify
  always_ff @(posedge ref_clk or posedge por)
  begin
    if (por)
    begin
      for (int i = 0; i < ARRAY_WORDS; i++)
        mem_q[i] <= 32'h0000_0000;
    end
    else if (op_q == fpes_pkg::OP_ARRAY && done && ~op_fault)
    begin
      for (int i = 0; i < ARRAY_WORDS; i++)
        mem_q[i] <= 32'hffff_ffff;
    end
  end

  // selector bits of each command write, kept for the decoder's late pulse
  always_ff @(posedge ref_clk or posedge rst_any)
  begin
    if (rst_any)
      cmd_sel_q <= 2'h0;
    else if (fl_wr)
      cmd_sel_q <= paddr[`FPES_ID_HI:`FPES_ID_LO];
  end

  // identity mode and its selector
  always_ff @(posedge ref_clk or posedge rst_any)
  begin
    if (rst_any)
    begin
      id_mode_q <= 1'b0;
      id_sel_q  <= 2'h0;
    end
    else if (cmd.rd_reset || cmd.pberase_go)
      id_mode_q <= 1'b0;
    else if (cmd.id_enter)
    begin
      id_mode_q <= 1'b1;
      id_sel_q  <= 2'h0;
    end
    else if (cmd.id_select)
      id_sel_q <= cmd_sel_q;
  end

endmodule

/* File: tb/fpes_cpu.sv */
/*
  Processor model: apb master, one transfer per request pulse.
  Assumes the bench waits for done before the next request.
*/
`timescale 1ns/10ps
module fpes_cpu (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // request from the bench
  input  wire logic        req,
  input  wire logic        wr,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  output logic             done = 1'b0,
  // apb master
  output logic             psel = 1'b0,
  output logic             penable = 1'b0,
  output logic             pwrite = 1'b0,
  output logic      [31:0] paddr = 32'h0,
  output logic      [31:0] pwdata = 32'h0,
  input  wire logic        pready
);
  always @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      done    <= 1'b0;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (psel && penable && pready)
      begin
        psel    <= 1'b0;
        penable <= 1'b0;
        done    <= 1'b1;
        paddr   <= ~paddr; // released bus shows no stale value
        pwdata  <= ~pwdata;
      end
      else if (psel)
        penable <= 1'b1;
      else if (req)
      begin
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= addr;
        pwdata <= wdata;
      end
    end
endmodule

/* File: tb/fpes_props.sv */
/*
  Port checker for fpes_top.
  Assumes it is bound into fpes_top with shortened timing parameters.
*/
`timescale 1ns/10ps
`include "fpes_defines.svh"
module fpes_props (
  // clock and resets
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        por,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // status
  input  wire logic        op_fault,
  input  wire logic        ready_flag
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst || por);

  logic rd_stat;
  logic rd_sec;
  logic flash;
  logic go7;
  assign rd_stat = pready && !pwrite && paddr == `FPES_STAT_ADDR;
  assign rd_sec  = pready && !pwrite && paddr == `FPES_SEC_ADDR;
  assign flash   = paddr[31:16] == `FPES_FLASH_HI;
  assign go7     = pready && pwrite && flash && pwdata[7:0] == `FPES_D_PBE;

  sequence s_busy_start;
    $fell(ready_flag);
  endsequence
  sequence s_fault;
    !ready_flag && op_fault;
  endsequence

  a_stat_bit0: assert property (rd_stat |-> prdata[0] == $past(ready_flag))
    else $error("status bit0 differs from ready flag");
  a_stat_rsvd: assert property (rd_stat |-> !prdata[31:22] && !prdata[15:1])
    else $error("status reserved bits not zero");
  a_sec_rsvd: assert property (rd_sec |-> prdata[31:1] == 31'h0)
    else $error("security reserved bits not zero");
  a_bad_addr: assert property (pready && !flash && !rd_sec && !rd_stat && !pwrite
    |-> pslverr)
    else $error("unmapped read without error");
  a_flash_ok: assert property (pready && flash |-> !pslverr)
    else $error("flash access flagged as error");
  a_one_pulse: assert property (pready |=> !pready)
    else $error("answer held over two cycles");
  a_busy_cause: assert property (s_busy_start |->
    $past(go7, 1) || $past(go7, 2) || $past(go7, 3))
    else $error("busy without final erase write");
  a_busy_hold: assert property (s_busy_start |-> !ready_flag [*3])
    else $error("busy period too short");
  a_fault_hold: assert property (s_fault |=> !ready_flag [*8])
    else $error("ready after fault without reset");
endmodule

bind fpes_top fpes_props u_fpes_props (.ref_clk, .rst, .por, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .op_fault, .ready_flag);

/* File: tb/testbench.sv */
/*
  Self-checking bench for fpes_top.
  Assumes fpes_cpu drives apb and fpes_props is bound.
*/
`timescale 1ns/10ps
`include "fpes_defines.svh"
module testbench;
  localparam logic [32:0] ALL = {33{1'b1}};
  localparam logic [31:0] IDB = 32'h0000_5a00; // arbitrary id codes
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        por = 1'b1;
  logic        op_fault = 1'b0;
  logic        req = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic        done, psel, penable, pwrite, pready, pslverr, ready_flag;
  logic [31:0] paddr, pwdata, prdata, v;
  logic [32:0] exp_q[$];
  logic [32:0] msk_q[$];
  int          mismatches = 0;
  int          num_checks = 0;
  int          seed = 96477;

  always #25 ref_clk = ~ref_clk;

  fpes_top #(.READ_WAIT_CYC(20), .ARRAY_ERASE_CYC(8), .PROT_ERASE_CYC(60),
    .PROT_INIT(6'h3f),
    .ID_CODE0(IDB), .ID_CODE1(IDB + 1), .ID_CODE2(IDB + 2), .ID_CODE3(IDB + 3))
    u_fpes_top (.ref_clk, .rst, .por, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .op_fault, .ready_flag);
  fpes_cpu u_fpes_cpu (.ref_clk, .rst, .req, .wr, .addr, .wdata, .done, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready);

  task automatic test_done();
    if (exp_q.size() != 0)
      bad("answer missing");
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic bad(input string m);
    mismatches++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic chk_bus(input logic [32:0] e, input logic [32:0] m, input logic [32:0] g);
    num_checks++;
    if (((g ^ e) & m) !== 33'h0)
      bad("bus answer");
  endtask
  task automatic chk_flag(input logic e);
    num_checks++;
    if (ready_flag !== e)
      bad("ready flag");
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    req   <= 1'b1;
    wr    <= w;
    addr  <= a;
    wdata <= d;
    @(posedge ref_clk);
    req <= 1'b0;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    while (done !== 1'b1 && n < 200);
    if (n >= 200)
    begin
      bad("bus timeout");
      test_done();
    end
  endtask
  task automatic rd(input logic [31:0] a, input logic [32:0] e, input logic [32:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wrt(input logic [31:0] a, input logic [31:0] d);
    exp_q.push_back(33'h0);
    msk_q.push_back({1'b1, 32'h0});
    apb(1'b1, a, d);
  endtask
  task automatic cmd(input logic [7:0] ab, input logic [7:0] d);
    wrt({`FPES_FLASH_HI, ab, 8'h00}, {24'h0, d});
  endtask
  task automatic seq3(input logic [7:0] d);
    cmd(`FPES_A_54, `FPES_D_AA);
    cmd(`FPES_A_AA, `FPES_D_55);
    cmd(`FPES_A_54, d);
  endtask
  task automatic erase();
    seq3(`FPES_D_PBE);
    seq3(`FPES_D_PBE);
    cmd(8'h00, `FPES_D_PBE);
  endtask
  task automatic wait_rdy(input logic e);
    int n;
    n = 0;
    while (ready_flag !== e && n < 500)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 500)
    begin
      bad("flag wait timeout");
      test_done();
    end
  endtask
  task automatic hw_reset(input logic p);
    @(posedge ref_clk);
    rst <= 1'b1;
    por <= p;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    por <= 1'b0;
    #1;
  endtask

  // answer monitor
  always @(posedge ref_clk)
    if (pready === 1'b1)
    begin
      if (exp_q.size() == 0)
        bad("unexpected answer");
      else
        chk_bus(exp_q.pop_front(), msk_q.pop_front(), {pslverr, prdata});
    end

  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    por <= 1'b0;
    rd(`FPES_STAT_ADDR, 33'h3f_0001, ALL);
    rd(`FPES_SEC_ADDR, 33'h1, ALL);
    rd(32'h4004_0510, {1'b1, 32'h0}, {1'b1, 32'h0});
    wrt(`FPES_STAT_ADDR, 32'hffff_ffff);
    rd(`FPES_STAT_ADDR, 33'h3f_0001, ALL);
    repeat (4)
    begin
      v = $random(seed);
      wrt(`FPES_SEC_ADDR, v);
      rd(`FPES_SEC_ADDR, {32'h0, v[0]}, ALL);
    end
    wrt(`FPES_SEC_ADDR, 32'h0);
    hw_reset(1'b0);
    rd(`FPES_SEC_ADDR, 33'h0, ALL);
    hw_reset(1'b1);
    rd(`FPES_SEC_ADDR, 33'h1, ALL);
    $display("test registers done");
    seq3(`FPES_D_ID);
    for (int k = 0; k < 4; k++)
    begin
      cmd({k[1:0], 6'h0}, 8'h00);
      rd(32'h0000_0040, {1'b0, IDB + 32'(k)}, ALL);
    end
    seq3(`FPES_D_RST);
    rd(32'h0, 33'h0, ALL);
    $display("test identity done");
    rd(`FPES_STAT_ADDR, 33'h3f_0001, ALL);
    erase();
    wait_rdy(1'b0);
    seq3(`FPES_D_ID);
    rd(`FPES_STAT_ADDR, 33'h3f_0000, ALL);
    wait_rdy(1'b1);
    rd(`FPES_STAT_ADDR, 33'h1, ALL);
    rd(32'h0, {1'b0, 32'hffff_ffff}, ALL);
    $display("test erase done");
    erase();
    wait_rdy(1'b0);
    op_fault <= 1'b1;
    repeat (80) @(posedge ref_clk);
    op_fault <= 1'b0;
    repeat (100) @(posedge ref_clk);
    #1;
    chk_flag(1'b0);
    rd(`FPES_STAT_ADDR, 33'h0, 33'h1);
    hw_reset(1'b0);
    chk_flag(1'b1);
    rd(`FPES_STAT_ADDR, 33'h1, ALL);
    $display("test fault done");
    test_done();
  end
endmodule
